// >>> flash_dev_model.sv
// behavioural byte flash device for the host bench
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
  parameter logic [7:0] DEV_ID = 8'hC3 // arbitrary value
) (
  input wire logic mclk,
  input wire logic chipSelect_n,
  input wire logic outputEnable_n,
  input wire logic writeEnable_n,
  input wire logic flashReset_n,
  input wire logic idModeHighVoltage,
  input wire logic [20:0] flashAddr,
  input wire logic [7:0] dqOut,
  output logic [7:0] dqIn,
  output logic readyBusyOutput
);
  logic [5:0] busyCnt_q = 6'h00;
  logic [7:0] last_q = 8'h00;
  logic togBit_q = 1'b0;
  // self-timed busy per written byte; reset low aborts it
  // no suspend: a busy device answers every read with status only
  always_ff @(posedge mclk) begin
    if (!flashReset_n) busyCnt_q <= 6'h00;
    else if (!chipSelect_n && !writeEnable_n) busyCnt_q <= 6'h28;
    else if (busyCnt_q != 6'h00) busyCnt_q <= busyCnt_q - 6'h01;
    if (!writeEnable_n) last_q <= dqOut;
    if (!outputEnable_n) togBit_q <= ~togBit_q; // one toggle per clock with oe low
  end
  // released pins show the inverted last byte, never a held value
  always_comb begin
    if (!flashReset_n || chipSelect_n || outputEnable_n) dqIn = ~last_q;
    else if (busyCnt_q != 6'h00) dqIn = {~last_q[7], togBit_q, last_q[5:0]};
    else if (idModeHighVoltage)
      dqIn = flashAddr[1] ? 8'h00 : (flashAddr[0] ? DEV_ID : MAKER_ID);
    else dqIn = flashAddr[7:0] ^ flashAddr[20:13];
  end
  assign readyBusyOutput = busyCnt_q == 6'h00;
endmodule : flash_dev_model

// >>> flash_host_ctrl.sv
// host side strobe controller for a byte wide sector flash
`timescale 1ns/1ps
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reqValid,
  input wire logic [1:0] reqOp,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqData,
  input wire logic waitDone,
  input wire logic [DATA_W-1:0] dqIn,
  input wire logic readyBusyOutput,
  output logic reqReady,
  output logic rspValid,
  output logic [DATA_W-1:0] rspData,
  output logic [ADDR_W-1:0] flashAddr,
  output logic [DATA_W-1:0] dqOut,
  output logic dqOe_n,
  output logic chipSelect_n,
  output logic outputEnable_n,
  output logic writeEnable_n,
  output logic flashReset_n,
  output logic idModeHighVoltage,
  output logic opDone
);
  // the wake counter is 16 bits wide and must count at least one cycle
  if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin : g_bad_wake
    $error("bad WAKE_CYCLES");
  end

  typedef enum logic [2:0] {
    ST_WAKE = 3'b000,
    ST_IDLE = 3'b001,
    ST_SETUP = 3'b010,
    ST_STROBE = 3'b011,
    ST_RECOVER = 3'b100,
    ST_POLL = 3'b101
  } state_e;

  state_e state_q;
  logic [15:0] cnt_q;
  logic [1:0] op_q;
  logic waitDone_q;
  logic [DATA_W-1:0] lastPoll_q;
  logic pollSeen_q;

  // count in cycles, cut to the counter width on purpose
  function automatic logic [15:0] cyc(input int n);
    cyc = 16'(n);
  endfunction : cyc

  // last cycle of a read strobe: data has settled for the full access time,
  // so the sample and the response pulse are both taken here
  function automatic logic readSampleNow(input state_e st, input logic [15:0] cnt,
                                         input logic [1:0] op);
    readSampleNow = st == ST_STROBE && cnt <= 16'h0001 && op != OP_WRITE;
  endfunction : readSampleNow

  // toggle bit equal on two successive reads: the device has stopped
  // its internal algorithm; one read alone cannot tell this
  function automatic logic toggleSteady(input logic [DATA_W-1:0] prev,
                                        input logic [DATA_W-1:0] now);
    toggleSteady = prev[TOGGLING_BIT] == now[TOGGLING_BIT];
  endfunction : toggleSteady

  // sequence: setup, strobe, recover, optional completion poll
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_WAKE;
      cnt_q <= cyc(WAKE_CYCLES);
      op_q <= OP_READ;
      waitDone_q <= 1'b0;
      pollSeen_q <= 1'b0;
      lastPoll_q <= 8'h00;
    end else begin
      case (state_q)
        // device needs wake time after reset released
        ST_WAKE: begin
          if (cnt_q <= 16'h0001) state_q <= ST_IDLE;
          else cnt_q <= cnt_q - 16'h0001;
        end
        ST_IDLE: begin
          if (reqValid) begin
            op_q <= reqOp;
            waitDone_q <= waitDone && reqOp == OP_WRITE;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          cnt_q <= cyc(op_q == OP_WRITE ? STROBE_CYC : ACCESS_CYC);
          state_q <= ST_STROBE;
        end
        ST_STROBE: begin
          if (cnt_q <= 16'h0001) state_q <= ST_RECOVER;
          else cnt_q <= cnt_q - 16'h0001;
        end
        ST_RECOVER: begin
          pollSeen_q <= 1'b0;
          // after a write with waitDone set, host holds off new commands until device finishes
          if (waitDone_q) state_q <= ST_POLL;
          else state_q <= ST_IDLE;
        end
        ST_POLL: begin
          // ready pin high and toggle bit steady means done
          if (readyBusyOutput && (!pollSeen_q || toggleSteady(lastPoll_q, dqIn))) begin
            if (pollSeen_q) state_q <= ST_IDLE;
          end
          pollSeen_q <= 1'b1;
          lastPoll_q <= dqIn;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // pin drive: we only in the strobe phase; oe in read strobe and poll; cs in setup, strobe and poll
  always_ff @(posedge mclk) begin
    if (rst) begin
      chipSelect_n <= 1'b1;
      outputEnable_n <= 1'b1;
      writeEnable_n <= 1'b1;
      dqOe_n <= 1'b1;
      dqOut <= 8'h00;
      flashAddr <= '0;
      idModeHighVoltage <= 1'b0;
      flashReset_n <= 1'b0; // reset low aborts device ops
    end else begin
      flashReset_n <= 1'b1;
      if (state_q == ST_IDLE && reqValid) begin
        flashAddr <= reqAddr; // latched by device on write
        dqOut <= reqData;
        // id and verify modes force select lines
        if (reqOp == OP_ID) begin
          flashAddr[PROTECT_VERIFY_BIT] <= 1'b0;
          flashAddr[THIRD_ID_BIT] <= 1'b0;
        end else if (reqOp == OP_PROT_VERIFY) begin
          flashAddr[ID_BYTE_SELECT_BIT] <= 1'b0;
          flashAddr[PROTECT_VERIFY_BIT] <= 1'b1;
          flashAddr[THIRD_ID_BIT] <= 1'b0;
        end
        idModeHighVoltage <= reqOp == OP_ID || reqOp == OP_PROT_VERIFY;
      end else if (state_q == ST_IDLE) begin
        idModeHighVoltage <= 1'b0;
      end
      chipSelect_n <= !(state_q == ST_SETUP || state_q == ST_STROBE || state_q == ST_POLL);
      // group protection needs high voltage on oe as well; this host never
      // lowers we while the id line is raised, so it cannot protect by accident
      writeEnable_n <= !(state_q == ST_STROBE && op_q == OP_WRITE);
      // oe only on reads so write and read never overlap
      outputEnable_n <= !((state_q == ST_STROBE && op_q != OP_WRITE) || state_q == ST_POLL);
      dqOe_n <= !((state_q == ST_SETUP || state_q == ST_STROBE) && op_q == OP_WRITE);
    end
  end

  // handshake and read data return
  always_ff @(posedge mclk) begin
    if (rst) begin
      reqReady <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 8'h00;
      opDone <= 1'b0;
    end else begin
      reqReady <= state_q == ST_IDLE && !reqValid;
      rspValid <= readSampleNow(state_q, cnt_q, op_q);
      if (readSampleNow(state_q, cnt_q, op_q)) rspData <= dqIn;
      // completion reported once device is back in read mode
      opDone <= state_q == ST_POLL && pollSeen_q && readyBusyOutput &&
                toggleSteady(lastPoll_q, dqIn);
    end
  end
endmodule : flash_host_ctrl

// >>> flash_host_pkg.sv
// constants shared by the flash host controller
package flash_host_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;
  localparam int SECTOR_COUNT = 32;
  localparam int SECTOR_LSB = 16;
  localparam int GROUP_SIZE = 4;
  localparam int GROUP_LSB = 18;
  localparam int ID_BYTE_SELECT_BIT = 0;
  localparam int PROTECT_VERIFY_BIT = 1;
  localparam int THIRD_ID_BIT = 6;
  localparam int POLLING_BIT = 7;
  localparam int TOGGLING_BIT = 6;
  localparam int CLK_PERIOD_NS = 8;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_NS = 120;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_NS = 500;
  localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ID = 2'h2;
  localparam logic [1:0] OP_PROT_VERIFY = 2'h3;
endpackage : flash_host_pkg

// >>> flash_host_props.sv
// pin protocol assertions for the flash host controller
`timescale 1ns/1ps
module flash_host_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic rspValid,
  input wire logic opDone,
  input wire logic readyBusyOutput,
  input wire logic dqOe_n,
  input wire logic chipSelect_n,
  input wire logic outputEnable_n,
  input wire logic writeEnable_n,
  input wire logic flashReset_n,
  input wire logic idModeHighVoltage
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  AST_RD_NO_WE: assert property (!outputEnable_n |-> writeEnable_n)
    else $error("oe and we low together");
  AST_WE_FRAME: assert property (!writeEnable_n |-> !chipSelect_n && outputEnable_n)
    else $error("write without cs or with oe");
  AST_DRIVE_OE: assert property (!dqOe_n |-> outputEnable_n)
    else $error("bus contention");
  AST_WE_WIDTH: assert property ($fell(writeEnable_n) |-> (!writeEnable_n)[*5] ##1 writeEnable_n)
    else $error("we pulse width");
  AST_RESET: assert property ($fell(rst) |-> !flashReset_n)
    else $error("flash reset not low");
  AST_VH_NO_WE: assert property (idModeHighVoltage |-> writeEnable_n)
    else $error("id read with we low");
  AST_RSP_OE: assert property (rspValid |-> !$past(outputEnable_n) || !$past(outputEnable_n, 2))
    else $error("response without read");
  AST_DONE_RDY: assert property (opDone |-> readyBusyOutput)
    else $error("done while busy");
endmodule : flash_host_props

// >>> tb.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module tb
  import flash_host_pkg::*;
;
  logic mclk, rst, reqValid, waitDone, readyBusyOutput, reqReady, rspValid, dqOe_n, opDone;
  logic chipSelect_n, outputEnable_n, writeEnable_n, flashReset_n, idModeHighVoltage;
  logic [1:0] reqOp;
  logic [20:0] reqAddr, flashAddr;
  logic [7:0] reqData, dqIn, rspData, dqOut;
  int errors = 0;
  int compares = 0;
  typedef struct {logic [1:0] op; logic [20:0] a; logic [7:0] e;} row_s;
  row_s rows[5] = '{'{OP_READ, 21'h1F_0012, 8'hEA}, '{OP_READ, 21'h00_00FF, 8'hFF},
    '{OP_ID, 21'h00_0000, 8'h3C}, '{OP_ID, 21'h00_0001, 8'hC3},
    '{OP_PROT_VERIFY, 21'h00_0002, 8'h00}};
  flash_host_ctrl #(.WAKE_CYCLES(2)) DUT (.*);
  flash_dev_model dev (.*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // bounded wait, sampled at the falling edge where outputs are settled
  task automatic waitFor(ref logic sig);
    int n = 0;
    @(negedge mclk);
    while (sig !== 1'b1 && n < 300) begin
      n++;
      @(negedge mclk);
    end
    if (n == 300) begin
      errors++;
      print_verdict();
    end
  endtask : waitFor
  task automatic doReq(input logic [1:0] op, input logic [20:0] a, input logic wd);
    waitFor(reqReady);
    @(posedge mclk);
    reqValid <= 1'b1;
    reqOp <= op;
    reqAddr <= a;
    reqData <= a[7:0];
    waitDone <= wd;
    @(posedge mclk);
    reqValid <= 1'b0;
  endtask : doReq
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial begin
    {rst, reqValid, reqOp, reqAddr, reqData, waitDone} = {1'b1, 33'h0};
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      doReq(rows[i].op, rows[i].a, 1'b0);
      waitFor(rspValid);
      check(rspData, rows[i].e, "rspData");
    end
    doReq(OP_WRITE, 21'h04_0010, 1'b1);
    waitFor(opDone);
    check({7'h00, readyBusyOutput}, 8'h01, "ready");
    doReq(OP_READ, 21'h00_00FF, 1'b0);
    waitFor(rspValid);
    check(rspData, 8'hFF, "read after program");
    // reset during the setup cycle of a write, before any strobe, must deselect and reset the device
    doReq(OP_WRITE, 21'h04_0011, 1'b1);
    rst <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    check({6'h00, chipSelect_n, flashReset_n}, 8'h02, "cs and reset");
    @(posedge mclk);
    rst <= 1'b0;
    doReq(OP_READ, 21'h00_00FF, 1'b0);
    waitFor(rspValid);
    check(rspData, 8'hFF, "read after reset");
    print_verdict();
  end
endmodule : tb
bind flash_host_ctrl flash_host_props chk (.*);
